/* File: src/ebrw_regs.svh */
// constants for the external bus ready wait controller
`ifndef EBRW_REGS_SVH
`define EBRW_REGS_SVH
`define EBRW_ADDR_W 24
`define EBRW_DATA_W 16
`define EBRW_NUM_WIN 4
`define EBRW_WIN_W 2
`define EBRW_REG_MODE 5'h00
`define EBRW_REG_TIMING0 5'h04
`define EBRW_REG_ADDR 5'h08
`define EBRW_REG_WDATA 5'h0C
`define EBRW_REG_RDATA 5'h10
`define EBRW_REG_STATUS 5'h14
`define EBRW_TIMING_RST 15'h0000
`define EBRW_RDY_TIMEOUT 8'hFF
`endif

/* File: src/ebrw_pkg.sv */
// types for the external bus ready wait controller
package ebrw_pkg;
   typedef enum logic [2:0]
   {
      EBRW_IDLE = 3'b000,
      EBRW_AB = 3'b001,
      EBRW_C = 3'b010,
      EBRW_D = 3'b011,
      EBRW_E = 3'b100,
      EBRW_F = 3'b101
   } ebrw_state_t;
   typedef struct packed
   {
      logic [1:0] tp_f;
      logic [4:0] tp_e;
      logic tp_d;
      logic [1:0] tp_c;
      logic tp_ab;
      logic rdy_en;
      logic rdy_async;
      logic rdy_pol;
      logic muxed;
   } ebrw_timing_t;
   typedef struct packed
   {
      logic [23:0] addr;
      logic [15:0] ad_out;
      logic ad_oe_n;
      logic [15:0] d_out;
      logic d_oe_n;
      logic ale;
      logic rd_n;
      logic wr_n;
      logic bhe_n;
      logic [3:0] cs_n;
   } ebrw_pins_t;
endpackage

/* File: src/ebrw_ctrl.sv */
// external bus master sequencer with ready wait states and avalon slave
`timescale 1ns/10ps
`include "ebrw_regs.svh"
module ebrw_ctrl
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_ready,
   input wire logic [15:0] i_muxed_addr_data,
   input wire logic [15:0] i_split_addr_data_mode_data,
   output logic [23:0] o_split_addr_data_mode_addr,
   output logic [15:0] o_muxed_addr_data,
   output logic o_muxed_oe_n,
   output logic [15:0] o_split_addr_data_mode_data,
   output logic o_split_addr_data_mode_oe_n,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_byte_high_en_n,
   output logic [3:0] o_cs_n,
   output logic o_bus_ref_clock_out
);
   ebrw_pkg::ebrw_state_t state;
   ebrw_pkg::ebrw_state_t next_state;
   ebrw_pkg::ebrw_timing_t timing [`EBRW_NUM_WIN];
   ebrw_pkg::ebrw_timing_t cur;
   ebrw_pkg::ebrw_pins_t pins;
   ebrw_pkg::ebrw_pins_t next_pins;
   logic [1:0] win;
   logic [23:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata;
   logic is_write;
   logic rdy_timeout;
   logic [5:0] cnt;
   logic [5:0] next_cnt;
   logic [7:0] wait_cnt;
   logic rdy_s1;
   logic rdy_s2;
   logic rdy_s3;
   logic clk_div;
   // bus start/ack
   logic start_pend;
   logic busy;
   logic done_pulse;
   // high in the second cycle of a read, when the registered data stand
   logic rd_ack;
   // decode
   wire wr_mode = i_avs_write && (i_avs_address == `EBRW_REG_MODE);
   wire wr_tim = i_avs_write && (i_avs_address[4:2] == 3'b001);
   wire wr_addr = i_avs_write && (i_avs_address == `EBRW_REG_ADDR);
   wire wr_wdata = i_avs_write && (i_avs_address == `EBRW_REG_WDATA);
   wire start_req = wr_mode && i_avs_writedata[0] && !busy;
   // a start write while busy is stalled, never dropped
   wire mode_stall = wr_mode && i_avs_writedata[0] && busy;
   // sync: two flops; async: one extra flop
   wire rdy_raw = cur.rdy_async ? rdy_s3 : rdy_s2;
   wire rdy_act = (rdy_raw == cur.rdy_pol);
   wire [5:0] e_len = {1'b0, cur.tp_e} + 6'h01;
   wire e_mand_done = (cnt >= e_len - 6'h01);
   // first sample point is one later in async mode
   wire sample_pt = e_mand_done && (!cur.rdy_async || cnt >= e_len);
   // the bound only ends a wait at a sample point, never before
   wire wait_expired = (wait_cnt == `EBRW_RDY_TIMEOUT);
   wire e_done = cur.rdy_en ? sample_pt && (rdy_act || wait_expired)
                            : e_mand_done;
   wire [31:0] status_word = {29'h0, rdy_timeout, is_write, busy};

   // reads take one wait state so the data stand at the accepting edge
   assign o_avs_waitrequest = mode_stall || (i_avs_read && !rd_ack);
   assign o_bus_ref_clock_out = clk_div;
   assign o_split_addr_data_mode_addr = pins.addr;
   assign o_muxed_addr_data = pins.ad_out;
   assign o_muxed_oe_n = pins.ad_oe_n;
   assign o_split_addr_data_mode_data = pins.d_out;
   assign o_split_addr_data_mode_oe_n = pins.d_oe_n;
   assign o_ale = pins.ale;
   assign o_rd_n = pins.rd_n;
   assign o_wr_n = pins.wr_n;
   assign o_byte_high_en_n = pins.bhe_n;
   assign o_cs_n = pins.cs_n;
   assign cur = timing[win];

   // reference clock toggles at half rate: the clock itself cannot be
   // routed to a data port, so bus edges fall on either of its edges
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         clk_div <= 1'b0;
      else
         clk_div <= ~clk_div;
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
         rdy_s3 <= 1'b0;
      end
      else
      begin
         rdy_s1 <= i_ready;
         rdy_s2 <= rdy_s1;
         rdy_s3 <= rdy_s2;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `EBRW_NUM_WIN; gi++)
      begin : g_win
         always_ff @(posedge i_clk or negedge i_nrst)
         begin
            if (!i_nrst)
               timing[gi] <= ebrw_pkg::ebrw_timing_t'(`EBRW_TIMING_RST);
            else if (wr_tim && i_avs_address[1:0] == 2'(gi)
                     && i_avs_byteenable[1:0] == 2'b11)
               timing[gi] <=
                  ebrw_pkg::ebrw_timing_t'(i_avs_writedata[14:0]);
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         addr_reg <= 24'h00_0000;
         wdata_reg <= 16'h0000;
         win <= 2'h0;
         is_write <= 1'b0;
      end
      else
      begin
         if (wr_addr)
            addr_reg <= i_avs_writedata[23:0];
         if (wr_wdata)
            wdata_reg <= i_avs_writedata[15:0];
         if (start_req)
         begin
            win <= i_avs_writedata[3:2];
            is_write <= i_avs_writedata[1];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         rd_ack <= 1'b0;
      else
         rd_ack <= i_avs_read && !rd_ack;
   end

   // loaded only in the first read cycle, so the answer cannot move
   // under the master at the edge where it is taken
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_avs_readdata <= 32'h0000_0000;
      else if (i_avs_read && !rd_ack)
      begin
         if (i_avs_address == `EBRW_REG_ADDR)
            o_avs_readdata <= {8'h00, addr_reg};
         else if (i_avs_address == `EBRW_REG_WDATA)
            o_avs_readdata <= {16'h0000, wdata_reg};
         else if (i_avs_address == `EBRW_REG_RDATA)
            o_avs_readdata <= {16'h0000, rdata};
         else if (i_avs_address == `EBRW_REG_STATUS)
            o_avs_readdata <= status_word;
         else if (i_avs_address[4:2] == 3'b001)
            o_avs_readdata <= {17'h0_0000, timing[i_avs_address[1:0]]};
         else
            o_avs_readdata <= 32'h0000_0000;
      end
   end

   always_comb
   begin
      next_state = state;
      next_cnt = cnt + 6'h01;
      case (state)
         ebrw_pkg::EBRW_IDLE:
         begin
            next_cnt = 6'h00;
            if (start_pend)
               next_state = ebrw_pkg::EBRW_AB;
         end
         ebrw_pkg::EBRW_AB:
            if (cnt >= {5'h00, cur.tp_ab})
            begin
               next_cnt = 6'h00;
               next_state = ebrw_pkg::EBRW_C;
            end
         ebrw_pkg::EBRW_C:
            if (cnt >= {4'h0, cur.tp_c})
            begin
               next_cnt = 6'h00;
               next_state = ebrw_pkg::EBRW_D;
            end
         ebrw_pkg::EBRW_D:
            if (cnt >= {5'h00, cur.tp_d})
            begin
               next_cnt = 6'h00;
               next_state = ebrw_pkg::EBRW_E;
            end
         ebrw_pkg::EBRW_E:
            // each extra clock here is one ready wait state
            if (e_done)
            begin
               next_cnt = 6'h00;
               next_state = ebrw_pkg::EBRW_F;
            end
            // hold the count at its top so a long wait cannot wrap it
            else if (&cnt)
               next_cnt = cnt;
         ebrw_pkg::EBRW_F:
            if (cnt >= {4'h0, cur.tp_f})
            begin
               next_cnt = 6'h00;
               next_state = ebrw_pkg::EBRW_IDLE;
            end
         default:
            next_state = ebrw_pkg::EBRW_IDLE;
      endcase
   end

   always_comb
   begin
      next_pins = pins;
      next_pins.ale = 1'b0;
      case (next_state)
         ebrw_pkg::EBRW_IDLE:
         begin
            next_pins.cs_n = 4'hF;
            next_pins.rd_n = 1'b1;
            next_pins.wr_n = 1'b1;
            next_pins.bhe_n = 1'b1;
            next_pins.ad_oe_n = 1'b1;
            next_pins.d_oe_n = 1'b1;
         end
         ebrw_pkg::EBRW_AB:
         begin
            next_pins.addr = addr_reg;
            next_pins.cs_n = ~(4'h1 << win);
            next_pins.bhe_n = 1'b0;
            next_pins.ale = (state == ebrw_pkg::EBRW_IDLE);
            next_pins.ad_out = addr_reg[15:0];
            next_pins.ad_oe_n = ~cur.muxed;
         end
         ebrw_pkg::EBRW_D:
         begin
            next_pins.ad_out = wdata_reg;
            next_pins.ad_oe_n = ~(cur.muxed && is_write);
            next_pins.d_out = wdata_reg;
            next_pins.d_oe_n = ~(!cur.muxed && is_write);
         end
         ebrw_pkg::EBRW_E:
         begin
            next_pins.rd_n = is_write;
            next_pins.wr_n = ~is_write;
         end
         ebrw_pkg::EBRW_F:
         begin
            next_pins.rd_n = 1'b1;
            next_pins.wr_n = 1'b1;
         end
         default:
            // command delay keeps every line as it was, bar the latch
            next_pins.ale = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state <= ebrw_pkg::EBRW_IDLE;
         cnt <= 6'h00;
         pins <= '{addr: 24'h00_0000, ad_out: 16'h0000, ad_oe_n: 1'b1,
                   d_out: 16'h0000, d_oe_n: 1'b1, ale: 1'b0, rd_n: 1'b1,
                   wr_n: 1'b1, bhe_n: 1'b1, cs_n: 4'hF};
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         pins <= next_pins;
      end
   end

   // read data latched on the edge that raises the read strobe; the
   // captured source is the data pins, so early address moves are harmless
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         rdata <= 16'h0000;
      else if (state == ebrw_pkg::EBRW_E && e_done && !is_write)
         rdata <= cur.muxed ? i_muxed_addr_data : i_split_addr_data_mode_data;
   end

   // a ready that never comes would hang the bus; give up after a bound
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wait_cnt <= 8'h00;
         rdy_timeout <= 1'b0;
      end
      else if (state != ebrw_pkg::EBRW_E)
         wait_cnt <= 8'h00;
      else
      begin
         wait_cnt <= wait_cnt + 8'h01;
         if (wait_cnt == `EBRW_RDY_TIMEOUT)
            rdy_timeout <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         start_pend <= 1'b0;
         busy <= 1'b0;
         done_pulse <= 1'b0;
      end
      else
      begin
         done_pulse <= (state == ebrw_pkg::EBRW_F) &&
                       (next_state == ebrw_pkg::EBRW_IDLE);
         if (start_req)
         begin
            start_pend <= 1'b1;
            busy <= 1'b1;
         end
         else if (state == ebrw_pkg::EBRW_IDLE && start_pend)
            start_pend <= 1'b0;
         else if (done_pulse)
            busy <= 1'b0;
      end
   end
endmodule // ebrw_ctrl

/* File: src/ebrw_unused_placeholder_none.sv */
// intentionally empty module set for this design
`timescale 1ns/10ps

/* File: dv/ebrw_props.sv */
// assertion checker for the bus ready wait controller
`timescale 1ns/10ps
module ebrw_props
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic i_ready,
   input wire logic [23:0] o_split_addr_data_mode_addr,
   input wire logic [15:0] o_muxed_addr_data,
   input wire logic o_muxed_oe_n,
   input wire logic o_split_addr_data_mode_oe_n,
   input wire logic o_ale,
   input wire logic o_rd_n,
   input wire logic o_wr_n,
   input wire logic [3:0] o_cs_n
);
   // shadow of the last timing word; one window runs at a time
   ebrw_pkg::ebrw_timing_t cfg;
   logic [8:0] cnt;
   logic [5:0] rh;
   wire stb = !(o_rd_n && o_wr_n);
   wire ract = i_ready == cfg.rdy_pol;
   wire [8:0] lim = {4'h0, cfg.tp_e} + 9'h001;
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cfg <= '0;
         cnt <= 9'h000;
         rh <= 6'h00;
      end
      else
      begin
         if (i_avs_write && i_avs_address[4:2] == 3'b001)
            cfg <= i_avs_writedata[14:0];
         cnt <= stb ? cnt + 9'h001 : 9'h000;
         rh <= {rh[4:0], ract};
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence cmd_end;
      $fell(stb);
   endsequence
   sequence rdy_late;
      stb && cfg.rdy_en && ract && cnt > lim;
   endsequence
   AST_CMD_EXCL: assert property (o_rd_n || o_wr_n)
      else $error("both strobes low");
   AST_CS_ONE: assert property ($onehot0(~o_cs_n) && !(stb && &o_cs_n))
      else $error("chip select wrong");
   AST_ALE_SETUP: assert property (o_ale |-> !stb)
      else $error("latch pulse during command");
   AST_IDLE_REL: assert property (&o_cs_n |-> o_muxed_oe_n && o_split_addr_data_mode_oe_n)
      else $error("lines driven while idle");
   AST_RD_REL: assert property (!o_rd_n |-> o_muxed_oe_n && o_split_addr_data_mode_oe_n)
      else $error("lines driven during read");
   AST_MUX_ADDR: assert property (o_ale && cfg.muxed |->
      !o_muxed_oe_n && o_muxed_addr_data == o_split_addr_data_mode_addr[15:0])
      else $error("shared lines lack address");
   AST_ADDR_HOLD: assert property (stb && $past(stb) |-> $stable(o_split_addr_data_mode_addr))
      else $error("address moved in command");
   AST_FIXED: assert property (cmd_end ##0 !cfg.rdy_en |-> cnt == lim)
      else $error("access length wrong");
   AST_MIN_ACC: assert property (cmd_end |-> cnt >= lim)
      else $error("access shorter than minimum");
   AST_WAIT: assert property (cmd_end ##0 cfg.rdy_en |-> rh != 6'h00)
      else $error("ended without ready");
   AST_RDY_END: assert property (rdy_late |-> ##[1:6] !stb)
      else $error("ready did not end access");
endmodule // ebrw_props

/* File: dv/ebrw_ext_mod.sv */
// behavioural external module: ready handshake and read data
`timescale 1ns/10ps
module ebrw_ext_mod
(
   input wire logic i_clk,
   input wire logic i_lclk,
   input wire logic i_link,
   input wire logic i_pol,
   input wire logic [7:0] i_wait,
   input wire logic [15:0] i_rdata,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   output logic o_ready,
   output logic [15:0] o_rdata
);
   int n = 0;
   logic hit = 1'b0;
   wire stb = !(i_rd_n && i_wr_n);
   // withdrawn when the strobe rises, so the next cycle never sees it
   assign o_ready = (stb && hit) ? i_pol : !i_pol;
   // released lines show the inverse, never a stale copy
   assign o_rdata = i_rd_n ? ~i_rdata : i_rdata;
   task automatic step;
      n = stb ? n + 1 : 0;
      hit <= stb && n > i_wait;
   endtask
   always @(posedge i_clk) if (!i_link) step();
   // link timing is unrelated to the bus clock; held until strobe rises
   always @(posedge i_lclk) if (i_link) step();
endmodule // ebrw_ext_mod

/* File: dv/tb.sv */
// self-checking bench for the bus ready wait controller
`timescale 1ns/10ps
module tb;
   typedef struct
   {
      logic [14:0] cfg;
      logic wr;
      logic [1:0] win;
      logic [23:0] a;
      logic [15:0] d;
      int w;
      logic lk;
   } ebrw_row_t;
   logic i_clk, i_nrst, lclk, i_avs_read, i_avs_write, i_ready;
   logic [4:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rdq;
   logic [3:0] i_avs_byteenable, o_cs_n, cscap;
   logic o_avs_waitrequest, o_muxed_oe_n, o_split_addr_data_mode_oe_n, o_ale;
   logic o_rd_n, o_wr_n, o_byte_high_en_n, o_bus_ref_clock_out;
   logic [15:0] i_muxed_addr_data, i_split_addr_data_mode_data, o_muxed_addr_data;
   logic [15:0] o_split_addr_data_mode_data, wcap, mcap, rdat;
   logic [23:0] o_split_addr_data_mode_addr, acap;
   logic pol, lk, shared_addr_data_mode, bcap;
   logic [7:0] wt;
   int fail_count = 0, checks_done = 0, lo, st, ls;
   wire stb = !(o_rd_n && o_wr_n);
   ebrw_row_t rows[8] = '{
      '{15'h0200, 1'b0, 2'h0, 24'h123456, 16'hA5C3, 0, 1'b0},
      '{15'h60F0, 1'b1, 2'h1, 24'hFEDCBA, 16'h3C5A, 0, 1'b0},
      '{15'h1F01, 1'b0, 2'h2, 24'h00FFFF, 16'h8001, 0, 1'b0},
      '{15'h0001, 1'b1, 2'h3, 24'hABCDEF, 16'h7FFE, 0, 1'b0},
      '{15'h010A, 1'b0, 2'h0, 24'h000001, 16'h1234, 6, 1'b0},
      '{15'h010C, 1'b1, 2'h0, 24'h800000, 16'hFFFF, 2, 1'b1},
      '{15'h0308, 1'b0, 2'h0, 24'h111111, 16'h0000, 0, 1'b0},
      '{15'h030F, 1'b0, 2'h0, 24'h222222, 16'h5555, 0, 1'b1}};
   assign i_muxed_addr_data = i_split_addr_data_mode_data;
   ebrw_ctrl i_dut (.*);
   ebrw_ext_mod i_ext (.i_clk(i_clk), .i_lclk(lclk), .i_link(lk),
      .i_pol(pol), .i_wait(wt), .i_rdata(rdat), .i_rd_n(o_rd_n),
      .i_wr_n(o_wr_n), .o_ready(i_ready), .o_rdata(i_split_addr_data_mode_data));
   // sampled on edges so a change at the closing edge cannot race
   always @(posedge i_clk)
   begin
      if (o_ale)
         mcap <= o_muxed_addr_data;
      if (stb)
      begin
         lo <= lo + 1;
         acap <= o_split_addr_data_mode_addr;
         cscap <= o_cs_n;
         bcap <= o_byte_high_en_n;
         wcap <= shared_addr_data_mode ? o_muxed_addr_data : o_split_addr_data_mode_data;
      end
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic av(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      st = 0;
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0 && st < 300)
      begin
         st++;
         @(posedge i_clk);
      end
      // read data stand at the very edge that ends the wait
      rdq = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
      if (st == 300)
      begin
         fail_count++;
         end_sim();
      end
   endtask
   task automatic idle;
      int k;
      k = 0;
      do
      begin
         av(1'b0, 5'h14, 32'h0);
         k++;
      end
      while (rdq[0] !== 1'b0 && k < 100);
      if (k == 100)
      begin
         fail_count++;
         end_sim();
      end
   endtask
   task automatic run(input ebrw_row_t r);
      av(1'b1, 5'h04 + {3'h0, r.win}, {17'h0, r.cfg});
      av(1'b1, 5'h08, {8'h00, r.a});
      av(1'b1, 5'h0C, {16'h0, r.d});
      pol <= r.cfg[1];
      shared_addr_data_mode <= r.cfg[0];
      wt <= r.w[7:0];
      lk <= r.lk;
      rdat <= r.d;
      lo = 0;
      av(1'b1, 5'h00, {28'h0, r.win, r.wr, 1'b1});
      idle();
      if (!r.wr)
         av(1'b0, 5'h10, 32'h0);
      check(r.wr ? wcap : rdq[15:0], r.d);
      check(cscap, 4'(~(4'h1 << r.win)));
      check(bcap, 1'b0);
      check(shared_addr_data_mode ? mcap : acap, shared_addr_data_mode ? r.a[15:0] : r.a);
      if (!r.cfg[3])
         check(lo, r.cfg[12:8] + 1);
      else
         check({31'h0, lo > r.w && lo > r.cfg[12:8]}, 32'h1);
   endtask
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial
   begin
      lclk = 1'b0;
      forever #100 lclk = ~lclk;
   end
   initial
   begin
      {i_nrst, i_avs_read, i_avs_write, pol, lk, shared_addr_data_mode} = 6'h00;
      {i_avs_address, i_avs_writedata, wt, rdat} = '0;
      i_avs_byteenable = 4'hF;
      lo = 0;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      check({o_cs_n, o_rd_n, o_wr_n, o_muxed_oe_n, o_split_addr_data_mode_oe_n, o_ale,
         o_byte_high_en_n, o_bus_ref_clock_out}, 32'h7FA);
      @(posedge i_clk);
      $display("reset test done");
      foreach (rows[i])
      begin
         run(rows[i]);
         $display("row %0d done", i);
      end
      run('{15'h0108, 1'b0, 2'h0, 24'h0A0A0A, 16'h0F0F, 3, 1'b0});
      ls = lo;
      run('{15'h010C, 1'b0, 2'h0, 24'h0A0A0A, 16'h0F0F, 3, 1'b0});
      check({31'h0, lo > ls}, 32'h1);
      $display("ready mode test done");
      av(1'b1, 5'h04, 32'h1F00);
      av(1'b1, 5'h00, 32'h3);
      av(1'b0, 5'h14, 32'h0);
      check(rdq[0], 1'b1);
      av(1'b1, 5'h00, 32'h3);
      check({31'h0, st > 0}, 32'h1);
      idle();
      av(1'b0, 5'h1C, 32'h0);
      check(rdq, 32'h0);
      $display("busy and unmapped tests done");
      // reset in the middle of a long read must idle the chip selects, strobes and output enables at once
      av(1'b1, 5'h00, 32'h1);
      st = 0;
      while (!stb && st < 300)
      begin
         st++;
         @(posedge i_clk);
      end
      check({31'h0, stb}, 32'h1);
      i_nrst <= 1'b0;
      @(posedge i_clk);
      check({o_cs_n, o_rd_n, o_wr_n, o_muxed_oe_n, o_split_addr_data_mode_oe_n},
         32'hFF);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      av(1'b0, 5'h14, 32'h0);
      check(rdq, 32'h0);
      $display("mid-run reset test done");
      end_sim();
   end
endmodule // tb
bind ebrw_ctrl ebrw_props i_props (.*);
